/* File: io_cs_pkg.sv */
package io_cs_pkg;

    // ************************************************************
    // Bus widths and field positions
    // ************************************************************
    localparam int ADDR_W     = 24;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int LANE_BIT   = 0;
    localparam int REG_LSB    = 1;
    localparam int REG_W      = 3;
    localparam int DEV_LSB    = 4;
    localparam int DEV_W      = 3;
    localparam int NUM_DEV    = 8;
    localparam int BASE_LSB   = 7;
    localparam int BASE_W     = 9;
    localparam int LINEAR_LSB = 1;
    localparam int LINEAR_W   = 15;
    localparam int PAGE_LSB   = 16;
    localparam int PAGE_W     = 8;

    // ************************************************************
    // Memory-mapped I/O window and reset values
    // ************************************************************
    localparam logic [PAGE_W-1:0] IO_PAGE = 8'hFE;
    localparam logic [BASE_W-1:0] BASE_RESET = 9'h000;

    // ************************************************************
    // Select schemes
    // ************************************************************
    typedef enum logic [2:0]
    {
        SCHEME_SEPARATE  = 3'b001,
        SCHEME_BYTE_ONLY = 3'b010,
        SCHEME_SINGLE    = 3'b100
    } scheme_e;

endpackage

/* File: byte_lane_steer.sv */
`timescale 1ns/1ps

module byte_lane_steer
(
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rstn,
    // Cycle qualifiers
    input  wire logic                           upperLane,
    input  wire logic                           readActive,
    input  wire logic                           writeActive,
    // Processor side
    input  wire logic [io_cs_pkg::DATA_W-1:0]   cpuWriteData,
    output logic      [io_cs_pkg::DATA_W-1:0]   cpuReadData,
    output logic                                cpuReadDataOe,
    // Peripheral side
    input  wire logic [io_cs_pkg::BYTE_W-1:0]   perReadData,
    output logic      [io_cs_pkg::BYTE_W-1:0]   perWriteData,
    output logic                                perWriteDataOe
);
    import io_cs_pkg::*;

    logic [DATA_W-1:0] next_cpuReadData;
    logic              next_cpuReadDataOe;
    logic [BYTE_W-1:0] next_perWriteData;
    logic              next_perWriteDataOe;

    // ************************************************************
    // Lane steering
    // ************************************************************
    // The byte is returned on both lanes, so the processor picks it from whichever
    // lane the address parity names without this block tracking the transfer size.
    always_comb
    begin
        next_perWriteData   = upperLane ? cpuWriteData[DATA_W-1:BYTE_W]
                                        : cpuWriteData[BYTE_W-1:0];
        next_perWriteDataOe = writeActive;
        next_cpuReadData    = {perReadData, perReadData};
        next_cpuReadDataOe  = readActive;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cpuReadData    <= '0;
            cpuReadDataOe  <= 1'b0;
            perWriteData   <= '0;
            perWriteDataOe <= 1'b0;
        end
        else
        begin
            cpuReadData    <= next_cpuReadData;
            cpuReadDataOe  <= next_cpuReadDataOe;
            perWriteData   <= next_perWriteData;
            perWriteDataOe <= next_perWriteDataOe;
        end
    end

endmodule

/* File: io_chip_select_decoder.sv */
`timescale 1ns/1ps


module io_chip_select_decoder
#(
    parameter logic [io_cs_pkg::BASE_W-1:0] IO_BASE = io_cs_pkg::BASE_RESET
)
(
    // Clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             rstn,
    // Configuration
    input  wire io_cs_pkg::scheme_e               scheme,
    input  wire logic                             memMapEnable,
    // Processor bus
    input  wire logic [io_cs_pkg::ADDR_W-1:0]     address,
    input  wire logic                             upperByteEnable_n,
    input  wire logic                             addressLatchEnable,
    input  wire logic                             memoryCycle,
    input  wire logic                             readRequest_n,
    input  wire logic                             writeRequest_n,
    // Processor data lanes
    input  wire logic [io_cs_pkg::DATA_W-1:0]     cpuWriteData,
    output logic      [io_cs_pkg::DATA_W-1:0]     cpuReadData,
    output logic                                  cpuReadDataOe,
    // Peripheral byte bus
    input  wire logic [io_cs_pkg::BYTE_W-1:0]     perReadData,
    output logic      [io_cs_pkg::BYTE_W-1:0]     perWriteData,
    output logic                                  perWriteDataOe,
    // Peripheral selects and commands
    output logic      [io_cs_pkg::NUM_DEV-1:0]    evenSelect,
    output logic      [io_cs_pkg::NUM_DEV-1:0]    oddSelect,
    output logic      [io_cs_pkg::NUM_DEV-1:0]    wordSelect,
    output logic      [io_cs_pkg::LINEAR_W-1:0]   linearSelect,
    output logic      [io_cs_pkg::REG_W-1:0]      registerAddress,
    output logic                                  ioReadCommand_n,
    output logic                                  ioWriteCommand_n
);
    import io_cs_pkg::*;

    // ************************************************************
    // Cycle decode
    // ************************************************************
    logic               addressBitZero;
    logic               upperActive;
    logic               lowerActive;
    logic               wordCycle;
    logic               ioHit;
    logic [DEV_W-1:0]   devIndex;
    logic [NUM_DEV-1:0] devOneHot;
    logic               evenHit;
    logic               oddHit;

    always_comb
    begin
        addressBitZero = address[LANE_BIT];
        upperActive    = !upperByteEnable_n;
        lowerActive    = !addressBitZero;
        wordCycle      = upperActive && lowerActive;
        ioHit          = (!memoryCycle
                          || (memMapEnable && address[PAGE_LSB +: PAGE_W] == IO_PAGE))
                         && address[BASE_LSB +: BASE_W] == IO_BASE;
        devIndex       = address[DEV_LSB +: DEV_W];
        devOneHot      = '0;
        devOneHot[devIndex] = 1'b1;
        // The even term needs bit zero low and the odd term needs the upper enable, so a byte
        // write to one neighbour never strobes the other.
        case (scheme)
            SCHEME_SEPARATE:
            begin
                evenHit = lowerActive;
                oddHit  = upperActive && (addressBitZero || wordCycle);
            end
            SCHEME_BYTE_ONLY:
            begin
                evenHit = lowerActive && !upperActive;
                oddHit  = upperActive && addressBitZero;
            end
            SCHEME_SINGLE:
            begin
                evenHit = lowerActive;
                oddHit  = upperActive && addressBitZero;
            end
            // An undefined scheme code selects no byte peripheral; word selects still work.
            default:
            begin
                evenHit = 1'b0;
                oddHit  = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Latched selects
    // ************************************************************
    logic [NUM_DEV-1:0]  next_evenSelect;
    logic [NUM_DEV-1:0]  next_oddSelect;
    logic [NUM_DEV-1:0]  next_wordSelect;
    logic [LINEAR_W-1:0] next_linearSelect;
    logic [REG_W-1:0]    next_registerAddress;
    logic                latchedIoHit;
    logic                latchedUpperLane;
    logic                next_latchedIoHit;
    logic                next_latchedUpperLane;

    // Selects change only at the latch strobe, which buys the decode the full
    // address phase at the cost of one clock of latency on every select.
    always_comb
    begin
        next_evenSelect       = evenSelect;
        next_oddSelect        = oddSelect;
        next_wordSelect       = wordSelect;
        next_linearSelect     = linearSelect;
        next_registerAddress  = registerAddress;
        next_latchedIoHit     = latchedIoHit;
        next_latchedUpperLane = latchedUpperLane;
        if (addressLatchEnable)
        begin
            next_evenSelect       = (ioHit && evenHit) ? devOneHot : '0;
            next_oddSelect        = (ioHit && oddHit) ? devOneHot : '0;
            next_wordSelect       = (ioHit && wordCycle) ? devOneHot : '0;
            next_linearSelect     = ioHit ? address[LINEAR_LSB +: LINEAR_W] : '0;
            next_registerAddress  = address[REG_LSB +: REG_W];
            next_latchedIoHit     = ioHit;
            next_latchedUpperLane = addressBitZero;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            evenSelect       <= '0;
            oddSelect        <= '0;
            wordSelect       <= '0;
            linearSelect     <= '0;
            registerAddress  <= '0;
            latchedIoHit     <= 1'b0;
            latchedUpperLane <= 1'b0;
        end
        else
        begin
            evenSelect       <= next_evenSelect;
            oddSelect        <= next_oddSelect;
            wordSelect       <= next_wordSelect;
            linearSelect     <= next_linearSelect;
            registerAddress  <= next_registerAddress;
            latchedIoHit     <= next_latchedIoHit;
            latchedUpperLane <= next_latchedUpperLane;
        end
    end

    // ************************************************************
    // Commands
    // ************************************************************
    logic next_ioReadCommand_n;
    logic next_ioWriteCommand_n;
    logic readActive;
    logic writeActive;

    // Commands trail the requests by one clock, so a command never opens before
    // the selects that it qualifies have settled. A bus cycle without an I/O hit
    // gets no command at all, which keeps memory cycles outside the mapped I/O page off the peripherals.
    always_comb
    begin
        readActive            = latchedIoHit && !readRequest_n;
        writeActive           = latchedIoHit && !writeRequest_n;
        next_ioReadCommand_n  = !readActive;
        next_ioWriteCommand_n = !writeActive;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ioReadCommand_n  <= 1'b1;
            ioWriteCommand_n <= 1'b1;
        end
        else
        begin
            ioReadCommand_n  <= next_ioReadCommand_n;
            ioWriteCommand_n <= next_ioWriteCommand_n;
        end
    end

    // ************************************************************
    // Byte lane multiplexer
    // ************************************************************
    byte_lane_steer laneSteer
    (
        .clk_sys        (clk_sys),
        .rstn           (rstn),
        .upperLane      (latchedUpperLane),
        .readActive     (readActive),
        .writeActive    (writeActive),
        .cpuWriteData   (cpuWriteData),
        .cpuReadData    (cpuReadData),
        .cpuReadDataOe  (cpuReadDataOe),
        .perReadData    (perReadData),
        .perWriteData   (perWriteData),
        .perWriteDataOe (perWriteDataOe)
    );

endmodule

/* File: io_chip_select_decoder_chk.sv */
`timescale 1ns/1ps

module io_chip_select_decoder_chk
#(
    parameter logic [io_cs_pkg::BASE_W-1:0] IO_BASE = io_cs_pkg::BASE_RESET
)
(
    // Clock and reset
    input wire logic                           clk_sys,
    input wire logic                           rstn,
    // Raw bus inputs
    input wire io_cs_pkg::scheme_e             scheme,
    input wire logic [io_cs_pkg::ADDR_W-1:0]   address,
    input wire logic                           upperByteEnable_n,
    input wire logic                           addressLatchEnable,
    input wire logic                           memoryCycle,
    // Decoded selects
    input wire logic [io_cs_pkg::NUM_DEV-1:0]  evenSelect,
    input wire logic [io_cs_pkg::NUM_DEV-1:0]  oddSelect,
    input wire logic [io_cs_pkg::NUM_DEV-1:0]  wordSelect,
    input wire logic [io_cs_pkg::LINEAR_W-1:0] linearSelect
);
    import io_cs_pkg::*;

    // ********************
    // Select properties
    // ********************
    logic ale;
    logic bitZero;
    logic ube;

    assign ale = addressLatchEnable;
    assign bitZero = address[0];
    assign ube = upperByteEnable_n;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    upper_odd_a:
        assert property (ale && !bitZero && scheme != SCHEME_SEPARATE |=> oddSelect == '0)
        else $error("odd select on even address");
    lower_even_a:
        assert property (ale && bitZero |=> evenSelect == '0)
        else $error("even select on odd address");
    enable_gate_a:
        assert property (ale && ube |=> oddSelect == '0 && wordSelect == '0)
        else $error("select without upper enable");
    word_pair_a:
        assert property (ale && scheme == SCHEME_SEPARATE && !bitZero && !ube |=>
            oddSelect == evenSelect && wordSelect == evenSelect) else $error("pair not selected");
    byte_only_a:
        assert property (ale && scheme == SCHEME_BYTE_ONLY && !bitZero && !ube |=>
            evenSelect == '0 && oddSelect == '0) else $error("byte select on word");
    single_word_a:
        assert property (ale && scheme == SCHEME_SINGLE && !bitZero && !ube |=>
            evenSelect == wordSelect && oddSelect == '0) else $error("single scheme word wrong");
    select_hold_a:
        assert property (!ale |=> $stable(evenSelect) && $stable(oddSelect) &&
            $stable(wordSelect) && $stable(linearSelect)) else $error("select moved");
    linear_follow_a:
        assert property (ale && !memoryCycle && address[15:7] == IO_BASE |=>
            linearSelect == $past(address[15:1])) else $error("linear select wrong");
endmodule

bind io_chip_select_decoder io_chip_select_decoder_chk #(.IO_BASE(IO_BASE)) u_chk
(
    .clk_sys, .rstn, .scheme, .address, .upperByteEnable_n, .addressLatchEnable, .memoryCycle,
    .evenSelect, .oddSelect, .wordSelect, .linearSelect
);

/* File: io_peripheral_model.sv */
`timescale 1ns/1ps

module io_peripheral_model
(
    // Clock and decoder outputs
    input  wire logic                          clk_sys,
    input  wire logic                          ioReadCommand_n,
    input  wire logic [io_cs_pkg::NUM_DEV-1:0] evenSelect,
    input  wire logic [io_cs_pkg::NUM_DEV-1:0] oddSelect,
    input  wire logic [io_cs_pkg::NUM_DEV-1:0] wordSelect,
    input  wire logic [io_cs_pkg::REG_W-1:0]   registerAddress,
    // Peripheral byte bus
    output logic      [io_cs_pkg::BYTE_W-1:0]  perReadData
);
    import io_cs_pkg::*;

    // ********************
    // Byte peripherals
    // ********************
    logic [BYTE_W-1:0] idle = 8'h5A;
    logic              drive;

    // The bus has no pull resistor, so a released bus shows a changing pattern.
    always @(posedge clk_sys)
        idle <= ~idle;

    assign drive = !ioReadCommand_n && (|{evenSelect, oddSelect, wordSelect});
    // Bit zero is fixed per lane, so registers are indexed from the bits above it.
    assign perReadData = drive ? (8'hA0 | {5'h00, registerAddress}) : idle;
endmodule

/* File: tb_io_chip_select_decoder.sv */
`timescale 1ns/1ps

module tb_io_chip_select_decoder;
    import io_cs_pkg::*;

    // ********************
    // Stimulus and scoreboard
    // ********************
    localparam logic [BASE_W-1:0] TB_BASE = 9'h0A5;
    typedef struct packed
    {
        logic [45:0] ctl;
        logic [7:0]  wb;
        logic        wchk;
        logic [7:0]  rb;
        logic        rchk;
    } note_s;

    logic                clk_sys, rstn, memMapEnable, upperByteEnable_n, addressLatchEnable;
    logic                memoryCycle, readRequest_n, writeRequest_n, cpuReadDataOe;
    logic                perWriteDataOe, ioReadCommand_n, ioWriteCommand_n, reqSeen;
    scheme_e             scheme;
    logic [ADDR_W-1:0]   address;
    logic [DATA_W-1:0]   cpuWriteData, cpuReadData;
    logic [BYTE_W-1:0]   perReadData, perWriteData;
    logic [NUM_DEV-1:0]  evenSelect, oddSelect, wordSelect;
    logic [LINEAR_W-1:0] linearSelect;
    logic [REG_W-1:0]    registerAddress;
    logic [45:0]         ctlSeen;
    int                  mismatches, samplesChecked;
    note_s               notes[$];
    note_s               seenNote;

    io_chip_select_decoder #(.IO_BASE(TB_BASE)) u_dut
    (
        .clk_sys, .rstn, .scheme, .memMapEnable, .address, .upperByteEnable_n,
        .addressLatchEnable, .memoryCycle, .readRequest_n, .writeRequest_n, .cpuWriteData,
        .cpuReadData, .cpuReadDataOe, .perReadData, .perWriteData, .perWriteDataOe,
        .evenSelect, .oddSelect, .wordSelect, .linearSelect, .registerAddress,
        .ioReadCommand_n, .ioWriteCommand_n
    );
    io_peripheral_model u_per
    (
        .clk_sys, .ioReadCommand_n, .evenSelect, .oddSelect, .wordSelect, .registerAddress,
        .perReadData
    );

    assign ctlSeen = {evenSelect, oddSelect, wordSelect, linearSelect, registerAddress,
                      ioReadCommand_n, ioWriteCommand_n, cpuReadDataOe, perWriteDataOe};

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checked %0d, mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic note_s predict(logic mem, logic [ADDR_W-1:0] a, logic ube, logic rd,
                                      logic [DATA_W-1:0] wd, logic last);
        logic       hit, word, known, ev, od;
        logic [7:0] oh;
        note_s      r;
        hit = (mem ? (memMapEnable && a[23:16] == IO_PAGE) : 1'b1) && a[15:7] == TB_BASE;
        word = !a[0] && !ube;
        known = scheme inside {SCHEME_SEPARATE, SCHEME_BYTE_ONLY, SCHEME_SINGLE};
        ev = hit && known && !a[0] && (scheme != SCHEME_BYTE_ONLY || ube);
        od = hit && known && !ube && (a[0] || scheme == SCHEME_SEPARATE);
        oh = 8'h01 << a[6:4];
        r.ctl = {ev ? oh : 8'h00, od ? oh : 8'h00, hit && word ? oh : 8'h00,
                 hit ? a[15:1] : 15'h0000, a[3:1], !(hit && rd), !(hit && !rd), hit && rd, hit && !rd};
        r.wb = a[0] ? wd[15:8] : wd[7:0];
        r.wchk = hit && !rd;
        r.rb = 8'hA0 | {5'h00, a[3:1]};
        r.rchk = last && (ev || od || (hit && word));
        return r;
    endfunction

    // The address lines are scrambled after the latch, so the selects must come from the latch.
    task automatic xfer(scheme_e s, logic mem, logic mm, logic [ADDR_W-1:0] a, logic ube,
                        logic rd, logic [DATA_W-1:0] wd);
        @(negedge clk_sys);
        scheme = s;
        memoryCycle = mem;
        memMapEnable = mm;
        address = a;
        upperByteEnable_n = ube;
        addressLatchEnable = 1'b1;
        @(negedge clk_sys);
        addressLatchEnable = 1'b0;
        address = ~a;
        upperByteEnable_n = !ube;
        memoryCycle = !mem;
        readRequest_n = !rd;
        writeRequest_n = rd;
        cpuWriteData = wd;
        notes.push_back(predict(mem, a, ube, rd, wd, 1'b0));
        if (rd)
        begin
            @(negedge clk_sys);
            notes.push_back(predict(mem, a, ube, rd, wd, 1'b1));
        end
        @(negedge clk_sys);
        readRequest_n = 1'b1;
        writeRequest_n = 1'b1;
    endtask

    always @(posedge clk_sys)
        reqSeen <= rstn && !(readRequest_n && writeRequest_n);

    always @(negedge clk_sys)
    begin
        if (reqSeen === 1'b1 && notes.size() > 0)
        begin
            seenNote = notes.pop_front();
            check("controls", ctlSeen, seenNote.ctl);
            if (seenNote.wchk)
                check("perWriteData", perWriteData, seenNote.wb);
            if (seenNote.rchk)
                check("cpuReadData", cpuReadData, {seenNote.rb, seenNote.rb});
        end
    end

    initial
    begin
        scheme_e           kinds[4];
        logic [ADDR_W-1:0] a;
        kinds = '{SCHEME_SEPARATE, SCHEME_BYTE_ONLY, SCHEME_SINGLE, scheme_e'(3'b000)};
        void'($urandom(32'ha293));
        rstn = 1'b0;
        scheme = SCHEME_SEPARATE;
        memMapEnable = 1'b0;
        address = '0;
        upperByteEnable_n = 1'b1;
        addressLatchEnable = 1'b0;
        memoryCycle = 1'b0;
        readRequest_n = 1'b1;
        writeRequest_n = 1'b1;
        cpuWriteData = '0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        check("resetIdle", ctlSeen, 46'h0000_0000_000C);
        repeat (3)
            for (int k = 0; k < 16; k++)
            begin
                a = {8'h00, TB_BASE, 7'($urandom())};
                a[0] = k[0];
                xfer(kinds[k / 4], 1'b0, 1'b0, a, k[1], 1'($urandom()), 16'($urandom()));
            end
        xfer(SCHEME_SINGLE, 1'b0, 1'b1, {8'h00, TB_BASE ^ 9'h100, 7'h31}, 1'b1, 1'b1, 16'hBEEF);
        xfer(SCHEME_SINGLE, 1'b1, 1'b1, {IO_PAGE, TB_BASE, 7'h7F}, 1'b0, 1'b1, 16'h0000);
        xfer(SCHEME_SEPARATE, 1'b1, 1'b1, {IO_PAGE, TB_BASE, 7'h70}, 1'b0, 1'b0, 16'hC35A);
        xfer(SCHEME_SEPARATE, 1'b1, 1'b0, {IO_PAGE, TB_BASE, 7'h70}, 1'b0, 1'b0, 16'hC35A);
        xfer(SCHEME_SEPARATE, 1'b1, 1'b1, {8'hFD, TB_BASE, 7'h70}, 1'b0, 1'b1, 16'hC35A);
        repeat (3) @(negedge clk_sys);
        check("notesLeft", 64'(notes.size()), 64'h0000);
        finish_test();
    end

    // About 200 cycles of traffic are expected, so 4000 cycles means a hang.
    initial
    begin
        #20000;
        mismatches++;
        finish_test();
    end
endmodule
